// *** edu_uart_top.sv ***
`timescale 1ns/1ps
// Behaviour
// - shift mode: data on rx line, clock on tx
// - shift mode bit rate is clock over sixteen
// - eight-bit frame: start, eight data, stop
// - eight-bit frame stores stop bit as ninth
// - eight-bit frame rate from timer or divisor
// - nine-bit frame: start, data, ninth, stop
// - transmit ninth bit comes from control field
// - receive ninth bit stored, stop discarded
// - fixed nine-bit rate clock/16 or clock/32
// - timer overflow halved when doubling bit clear
// - variable nine-bit mode uses variable rate
// - divisor built from high and low registers
// - divisor generators run on oscillator clock
// - each port owns its divisor generator
// - three rate sources, no timer 2
// - timer 1 overflow delivered even when stopped
// - eleven low bit times flag a break
module edu_uart_top (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_t1_ovf,
  input  wire logic [1:0]  i_rxd,
  output logic      [1:0]  o_rxd_out,
  output logic      [1:0]  o_rxd_oe,
  output logic      [1:0]  o_txd,
  output logic             o_irq
);

  typedef struct packed {
    logic [1:0]  mode;
    logic        ren;
    logic        tb8;
    logic        rb8;
    logic        brgsel;
    logic [7:0]  rxdata;
    logic [15:0] div;
    logic        tx_busy;
    logic [10:0] tx_sh;
    logic [3:0]  tx_ph;
    logic [3:0]  tx_bits;
    logic        rx_busy;
    logic [9:0]  rx_sh;
    logic [3:0]  rx_ph;
    logic [3:0]  rx_bits;
    logic [7:0]  brk_cnt;
    logic        brk_seen;
    logic [1:0]  rx_sync;
    logic        rx_prev;
    logic        txd;
    logic        rxd_out;
    logic        rxd_oe;
  } edu_port_s;

  typedef struct packed {
    edu_port_s [1:0] port;
    logic            smod;
    logic            t1half;
    logic            half;
    logic [5:0]      irq_st;
    logic [5:0]      irq_en;
    logic            irq;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } edu_top_s;

  edu_top_s   q;
  edu_top_s   d;
  logic [1:0] brg_tick;
  logic [1:0] rx_done;

  function automatic logic port_hit(input logic [7:0] a);
    return a < edu_pkg::OFF_POWER_CONTROL_REGISTER;
  endfunction

  function automatic logic [7:0] port_off(input logic [7:0] a);
    return a & ~edu_pkg::PORT_STRIDE;
  endfunction

  genvar g;
  generate
    for (g = 0; g < edu_pkg::NPORT; g++) begin : gen_port
      edu_brg #(
        .W (16)
      ) u_brg (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_en      (q.port[g].brgsel),
        .i_div     (q.port[g].div),
        .o_tick    (brg_tick[g])
      );
      assign o_txd[g]     = q.port[g].txd;
      assign o_rxd_out[g] = q.port[g].rxd_out;
      assign o_rxd_oe[g]  = q.port[g].rxd_oe;
    end
  endgenerate

  always_comb begin
    edu_port_s p;
    edu_port_s np;
    logic [5:0] ev;
    logic [5:0] clr;
    logic [9:0] sh;
    logic [3:0] lastb;
    logic       t16;
    logic       t1t;
    logic       rxb;
    logic       acc;
    logic       wr;
    logic       hit;
    logic [7:0] off;
    p     = q.port[0];
    np    = q.port[0];
    ev    = '0;
    clr   = '0;
    sh    = '0;
    lastb = '0;
    t16   = 1'b0;
    rxb   = 1'b0;
    rx_done = '0;
    d     = q;
    acc   = i_psel & i_penable;
    wr    = acc & i_pwrite & q.pready;
    hit   = port_hit(i_paddr);
    off   = port_off(i_paddr);
    t1t   = i_t1_ovf & (q.smod | q.t1half);
    if (i_t1_ovf) begin
      d.t1half = ~q.t1half;
    end
    d.half = ~q.half;
    for (int n = 0; n < edu_pkg::NPORT; n++) begin
      p  = q.port[n];
      np = p;
      np.rx_sync = {p.rx_sync[0], i_rxd[n]};
      rxb        = p.rx_sync[1];
      np.rx_prev = rxb;
      case (p.mode)
        edu_pkg::MODE_SHIFT:  t16 = 1'b1;
        edu_pkg::MODE_F9_FIX: t16 = q.smod | q.half;
        default:              t16 = p.brgsel ? brg_tick[n] : t1t;
      endcase
      case (p.mode)
        edu_pkg::MODE_SHIFT: lastb = edu_pkg::M0_LAST;
        edu_pkg::MODE_F8:    lastb = edu_pkg::F8_LAST;
        default:             lastb = edu_pkg::F9_LAST;
      endcase
      // break detect
      if (p.mode == edu_pkg::MODE_SHIFT || rxb) begin
        np.brk_cnt  = '0;
        np.brk_seen = 1'b0;
      end else if (t16 && p.brk_cnt != edu_pkg::BREAK_TICKS) begin
        np.brk_cnt = p.brk_cnt + 8'h01;
        if (np.brk_cnt == edu_pkg::BREAK_TICKS) begin
          np.brk_seen = 1'b1;
          ev[3*n+edu_pkg::EV_BRK] = 1'b1;
        end
      end
      // transmitter
      if (p.tx_busy && (p.mode == edu_pkg::MODE_SHIFT || t16)) begin
        np.tx_ph = p.tx_ph + 4'h1;
        if (p.tx_ph == edu_pkg::PH_LAST) begin
          np.tx_sh   = {1'b1, p.tx_sh[10:1]};
          np.tx_bits = p.tx_bits + 4'h1;
          if (p.tx_bits == lastb) begin
            np.tx_busy = 1'b0;
            ev[3*n+edu_pkg::EV_TX] = 1'b1;
          end
        end
      end
      // receiver
      if (p.rx_busy) begin
        if (p.mode == edu_pkg::MODE_SHIFT || t16) begin
          np.rx_ph = p.rx_ph + 4'h1;
          if (p.rx_ph == edu_pkg::PH_LAST) begin
            sh         = {rxb, p.rx_sh[9:1]};
            np.rx_sh   = sh;
            np.rx_bits = p.rx_bits + 4'h1;
            if (p.mode == edu_pkg::MODE_SHIFT) begin
              if (p.rx_bits == lastb) begin
                np.rx_busy = 1'b0;
                np.rxdata  = sh[9:2];
                ev[3*n+edu_pkg::EV_RX] = 1'b1;
              end
            end else if (p.rx_bits == 4'h0 && rxb) begin
              np.rx_busy = 1'b0;
            end else if (p.rx_bits == lastb) begin
              np.rx_busy = 1'b0;
              rx_done[n] = 1'b1;
              ev[3*n+edu_pkg::EV_RX] = 1'b1;
              if (p.mode == edu_pkg::MODE_F8) begin
                np.rxdata = sh[8:1];
                np.rb8    = sh[9];
              end else begin
                np.rxdata = sh[7:0];
                np.rb8    = sh[8];
              end
            end
          end
        end
      end else if (p.ren && p.mode != edu_pkg::MODE_SHIFT &&
                   p.rx_prev && !rxb) begin
        np.rx_busy = 1'b1;
        np.rx_ph   = edu_pkg::PH_START;
        np.rx_bits = 4'h0;
      end
      // pins
      if (p.mode == edu_pkg::MODE_SHIFT) begin
        np.txd = p.tx_busy ? p.tx_ph[3] :
                 (p.rx_busy ? p.rx_ph[3] : 1'b1);
      end else begin
        np.txd = p.tx_busy ? p.tx_sh[0] : 1'b1;
      end
      np.rxd_oe  = (p.mode == edu_pkg::MODE_SHIFT) && p.tx_busy;
      np.rxd_out = p.tx_busy ? p.tx_sh[0] : 1'b1;
      // register writes
      if (wr && hit && int'(i_paddr[5]) == n) begin
        case (off)
          edu_pkg::OFF_CTRL: begin
            np.mode   = i_pwdata[edu_pkg::CTRL_MODE +: 2];
            np.ren    = i_pwdata[edu_pkg::CTRL_REN];
            np.tb8    = i_pwdata[edu_pkg::CTRL_TB8];
            np.brgsel = i_pwdata[edu_pkg::CTRL_BRG];
            if (np.mode == edu_pkg::MODE_SHIFT && np.ren &&
                !p.rx_busy && !p.tx_busy) begin
              np.rx_busy = 1'b1;
              np.rx_ph   = 4'h0;
              np.rx_bits = 4'h0;
            end
          end
          edu_pkg::OFF_DATA: begin
            if (!p.tx_busy) begin
              np.tx_busy = 1'b1;
              np.tx_ph   = 4'h0;
              np.tx_bits = 4'h0;
              if (p.mode == edu_pkg::MODE_SHIFT) begin
                np.tx_sh = {3'h7, i_pwdata[7:0]};
              end else begin
                np.tx_sh = {1'b1,
                            (p.mode == edu_pkg::MODE_F8) ? 1'b1 : p.tb8,
                            i_pwdata[7:0], 1'b0};
              end
            end
          end
          edu_pkg::OFF_DIVH: np.div[15:8] = i_pwdata[7:0];
          edu_pkg::OFF_DIVL: np.div[7:0]  = i_pwdata[7:0];
          default: ;
        endcase
      end
      d.port[n] = np;
    end
    if (wr && !hit) begin
      case (i_paddr)
        edu_pkg::OFF_POWER_CONTROL_REGISTER:
          d.smod = i_pwdata[edu_pkg::POWER_CONTROL_REGISTER_SMOD];
        edu_pkg::OFF_ICLR: clr = i_pwdata[5:0];
        edu_pkg::OFF_IEN:  d.irq_en = i_pwdata[5:0];
        default: ;
      endcase
    end
    d.irq_st = (q.irq_st & ~clr) | ev;
    d.irq    = |(d.irq_st & d.irq_en);
    // apb answer, one wait state
    d.pready  = acc & ~q.pready;
    d.pslverr = 1'b0;
    if (acc && !q.pready) begin
      d.prdata = '0;
      p = q.port[i_paddr[5]];
      if (i_paddr[1:0] != 2'h0) begin
        d.pslverr = 1'b1;
      end else if (hit) begin
        case (off)
          edu_pkg::OFF_CTRL: begin
            d.prdata[edu_pkg::CTRL_MODE +: 2] = p.mode;
            d.prdata[edu_pkg::CTRL_REN]       = p.ren;
            d.prdata[edu_pkg::CTRL_TB8]       = p.tb8;
            d.prdata[edu_pkg::CTRL_RB8]       = p.rb8;
            d.prdata[edu_pkg::CTRL_BRG]       = p.brgsel;
          end
          edu_pkg::OFF_DATA: d.prdata[7:0] = p.rxdata;
          edu_pkg::OFF_STAT: begin
            d.prdata[edu_pkg::STAT_TXB] = p.tx_busy;
            d.prdata[edu_pkg::STAT_RXB] = p.rx_busy;
            d.prdata[edu_pkg::STAT_BRK] = p.brk_seen;
          end
          edu_pkg::OFF_DIVH: d.prdata[7:0] = p.div[15:8];
          edu_pkg::OFF_DIVL: d.prdata[7:0] = p.div[7:0];
          default: d.pslverr = 1'b1;
        endcase
      end else begin
        case (i_paddr)
          edu_pkg::OFF_POWER_CONTROL_REGISTER:  d.prdata[edu_pkg::POWER_CONTROL_REGISTER_SMOD] = q.smod;
          edu_pkg::OFF_ISTAT: d.prdata[5:0] = q.irq_st;
          edu_pkg::OFF_ICLR:  d.prdata = '0;
          edu_pkg::OFF_IEN:   d.prdata[5:0] = q.irq_en;
          default: d.pslverr = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
      for (int n = 0; n < edu_pkg::NPORT; n++) begin
        q.port[n].txd     <= 1'b1;
        q.port[n].rxd_out <= 1'b1;
        q.port[n].div     <= edu_pkg::DIV_RST;
      end
    end else begin
      q <= d;
    end
  end

  assign o_prdata  = q.prdata;
  assign o_pready  = q.pready;
  assign o_pslverr = q.pslverr;
  assign o_irq     = q.irq;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_clk_low8;
    (!o_txd[0])[*8];
  endsequence

  sequence s_clk_high8;
    o_txd[0][*8];
  endsequence

  a_pready_after_setup: assert property (
    $rose(o_pready) |-> $past(i_psel & i_penable))
    else $error("pready without access phase");

  a_shift_clock_shape: assert property (
    (q.port[0].mode == edu_pkg::MODE_SHIFT && q.port[0].tx_busy &&
     q.port[0].tx_ph == 4'h0) |=> s_clk_low8 ##1 s_clk_high8)
    else $error("shift clock not 8 low then 8 high");

  a_shift_drives_rx: assert property (
    (q.port[0].mode == edu_pkg::MODE_SHIFT && q.port[0].tx_busy)
    |=> o_rxd_oe[0])
    else $error("rx line not driven in shift transmit");

  a_async_start_bit: assert property (
    ($rose(q.port[0].tx_busy) && q.port[0].mode != edu_pkg::MODE_SHIFT)
    |=> !o_txd[0])
    else $error("frame does not open with low start bit");

  a_idle_line_high: assert property (
    (!q.port[0].tx_busy && q.port[0].mode != edu_pkg::MODE_SHIFT
     && $past(!q.port[0].tx_busy)) |=> o_txd[0])
    else $error("idle transmit line not high");

  a_stop_into_rb8: assert property (
    (rx_done[0] && q.port[0].mode == edu_pkg::MODE_F8)
    |=> q.port[0].rb8 == $past(q.port[0].rx_sync[1]))
    else $error("stop bit not stored as ninth bit");

  a_ninth_into_rb8: assert property (
    (rx_done[0] && q.port[0].mode[1])
    |=> q.port[0].rb8 == $past(q.port[0].rx_sh[9]))
    else $error("ninth bit not stored");

  a_fixed_half_rate: assert property (
    (q.port[0].mode == edu_pkg::MODE_F9_FIX && !q.smod &&
     q.port[0].tx_busy && $changed(q.port[0].tx_ph) &&
     $past(q.port[0].tx_busy)) |=> $stable(q.port[0].tx_ph))
    else $error("fixed nine-bit rate not halved");

  a_break_flag: assert property (
    (q.port[0].brk_cnt == edu_pkg::BREAK_TICKS) |-> q.port[0].brk_seen)
    else $error("break count reached without flag");

  a_irq_level: assert property (
    o_irq == |(q.irq_st & q.irq_en))
    else $error("interrupt output disagrees with status");

endmodule

// *** edu_pkg.sv ***
package edu_pkg;

  localparam int NPORT = 2;
  localparam int NEV   = 6;

  // clock and bit timing
  localparam int CLK_HZ      = 25_000_000;
  localparam int M0_DIV      = 16;
  localparam int OVS         = 16;
  localparam int BREAK_BITS  = 11;
  localparam logic [7:0] BREAK_TICKS = 8'(BREAK_BITS * OVS);
  localparam logic [3:0] M0_LAST     = 4'h7;
  localparam logic [3:0] F8_LAST     = 4'h9;
  localparam logic [3:0] F9_LAST     = 4'ha;
  localparam logic [3:0] PH_LAST     = 4'(OVS - 1);
  localparam logic [3:0] PH_START    = 4'(OVS / 2);

  // register offsets
  localparam logic [7:0] PORT_STRIDE = 8'h20;
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_DATA    = 8'h04;
  localparam logic [7:0] OFF_STAT    = 8'h08;
  localparam logic [7:0] OFF_DIVH    = 8'h0c;
  localparam logic [7:0] OFF_DIVL    = 8'h10;
  localparam logic [7:0] OFF_POWER_CONTROL_REGISTER    = 8'h40;
  localparam logic [7:0] OFF_ISTAT   = 8'h44;
  localparam logic [7:0] OFF_ICLR    = 8'h48;
  localparam logic [7:0] OFF_IEN     = 8'h4c;

  // field positions
  localparam int CTRL_MODE = 6;
  localparam int CTRL_REN  = 4;
  localparam int CTRL_TB8  = 3;
  localparam int CTRL_RB8  = 2;
  localparam int CTRL_BRG  = 0;
  localparam int STAT_TXB  = 0;
  localparam int STAT_RXB  = 1;
  localparam int STAT_BRK  = 2;
  localparam int POWER_CONTROL_REGISTER_SMOD = 7;
  localparam int EV_TX     = 0;
  localparam int EV_RX     = 1;
  localparam int EV_BRK    = 2;

  // reset values
  localparam logic [15:0] DIV_RST = 16'h0000;

  typedef enum logic [1:0] {
    MODE_SHIFT, MODE_F8, MODE_F9_FIX, MODE_F9_VAR
  } edu_mode_e;

endpackage

// *** edu_brg.sv ***
`timescale 1ns/1ps
module edu_brg #(
  parameter int W = 16
) (
  input  wire logic         i_mclk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_div,
  output logic              o_tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } edu_brg_s;

  edu_brg_s q;
  edu_brg_s d;

  // one tick every i_div+1 oscillator cycles
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (!i_en) begin
      d.cnt = i_div;
    end else if (q.cnt == '0) begin
      d.cnt  = i_div;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt - W'(1);
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_tick = q.tick;

endmodule

// *** edu_far_end.sv ***
`timescale 1ns/1ps
module edu_far_end (
  input  wire logic i_clk,
  input  wire logic i_txd,
  input  wire logic i_line,
  output logic      o_drv
);
  int cyc = 0;

  initial o_drv = 1'b1;

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
  end

  task automatic wait_lvl(input logic v);
    int k;
    k = 0;
    while (i_txd !== v && k < 4000) begin
      @(posedge i_clk);
      k++;
    end
  endtask

  // samples a frame at bit centres, start bit in b[0]
  task automatic get_frame(input int n, input int per, output logic [10:0] b);
    b = 11'h000;
    wait_lvl(1'b0);
    repeat (per / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      b[i] = i_txd;
      repeat (per) @(posedge i_clk);
    end
  endtask

  // drives a frame lsb first, line back to idle high after
  task automatic send_frame(input logic [10:0] b, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      o_drv <= b[i];
      repeat (per) @(posedge i_clk);
    end
    o_drv <= 1'b1;
  endtask

  // shift mode: data taken on each rising shift clock
  task automatic get_shift(output logic [7:0] d, output int span);
    int t0;
    t0 = 0;
    for (int i = 0; i < 8; i++) begin
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      d[i] = i_line;
      if (i == 0) t0 = cyc;
    end
    span = cyc - t0;
  endtask

  // shift mode: new bit placed in each low half
  task automatic feed_shift(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      wait_lvl(1'b0);
      o_drv <= d[i];
      wait_lvl(1'b1);
    end
    repeat (12) @(posedge i_clk);
    o_drv <= 1'b1;
  endtask
endmodule

// *** enhanced_dual_uart_tb.sv ***
`timescale 1ns/1ps
module enhanced_dual_uart_tb;
  localparam logic [7:0] CTL = edu_pkg::OFF_CTRL;
  localparam logic [7:0] DAT = edu_pkg::OFF_DATA;
  localparam logic [7:0] STA = edu_pkg::OFF_STAT;
  localparam logic [7:0] DVL = edu_pkg::OFF_DIVL;
  localparam logic [7:0] PCN = edu_pkg::OFF_POWER_CONTROL_REGISTER;
  localparam logic [7:0] IST = edu_pkg::OFF_ISTAT;
  localparam logic [7:0] ICL = edu_pkg::OFF_ICLR;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        t1_ovf;
  logic        t1_run;
  logic [1:0]  rxd;
  logic [1:0]  rxd_out;
  logic [1:0]  rxd_oe;
  logic [1:0]  txd;
  logic        irq;
  logic        drv0;
  logic        drv1;
  logic [31:0] rv;
  logic        ev;
  logic [10:0] fr;
  logic [7:0]  sd;
  int          span;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;

  assign rxd[0] = rxd_oe[0] ? rxd_out[0] : drv0;
  assign rxd[1] = rxd_oe[1] ? rxd_out[1] : drv1;

  edu_uart_top dut (
    .i_mclk    (clk),
    .i_sys_rst (rst),
    .i_psel    (psel),
    .i_penable (penable),
    .i_pwrite  (pwrite),
    .i_paddr   (paddr),
    .i_pwdata  (pwdata),
    .o_prdata  (prdata),
    .o_pready  (pready),
    .o_pslverr (pslverr),
    .i_t1_ovf  (t1_ovf),
    .i_rxd     (rxd),
    .o_rxd_out (rxd_out),
    .o_rxd_oe  (rxd_oe),
    .o_txd     (txd),
    .o_irq     (irq)
  );

  edu_far_end far0 (
    .i_clk  (clk),
    .i_txd  (txd[0]),
    .i_line (rxd[0]),
    .o_drv  (drv0)
  );

  edu_far_end far1 (
    .i_clk  (clk),
    .i_txd  (txd[1]),
    .i_line (rxd[1]),
    .o_drv  (drv1)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    t1_ovf <= t1_run & ~t1_ovf;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      final_report();
    end
  end

  function automatic logic [7:0] ra(input int p, input logic [7:0] o);
    return (p == 1 ? edu_pkg::PORT_STRIDE : 8'h00) + o;
  endfunction

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) fails++;
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask

  task automatic tx_frame(input int p, input logic [7:0] c, input logic [7:0] d,
                          input int n, input int per, input logic [10:0] e);
    int k;
    k = 0;
    wr(ra(p, CTL), c);
    fork
      wr(ra(p, DAT), d);
      if (p == 0) far0.get_frame(n, per, fr);
      else far1.get_frame(n, per, fr);
    join
    chk("tx frame", {21'h0, e}, {21'h0, fr});
    do begin
      rd(ra(p, STA));
      k++;
    end while (rv[edu_pkg::STAT_TXB] !== 1'b0 && k < 100);
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    t1_ovf = 1'b0;
    t1_run = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(ra(1, edu_pkg::OFF_DIVH));
    chk("divh1 reset", 32'h0, rv);
    wr(ra(0, edu_pkg::OFF_DIVH), 8'ha7);
    rd(ra(0, edu_pkg::OFF_DIVH));
    chk("divh0", 32'ha7, rv);
    rd(ra(1, edu_pkg::OFF_DIVH));
    chk("divh1 apart", 32'h0, rv);
    wr(ra(0, edu_pkg::OFF_DIVH), 8'h00);
    rd(8'h14);
    chk("unmapped err", 32'h1, {31'h0, ev});
    rd(ICL);
    chk("clear reads 0", 32'h0, rv);
    $display("test registers done");
    tx_frame(0, 8'h41, 8'ha5, 10, 16, {1'b1, 8'ha5, 1'b0});
    rd(IST);
    chk("istat tx", 32'h1, rv);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(edu_pkg::OFF_IEN, 8'h01);
    rd(IST);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(ICL, 8'h01);
    rd(IST);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("test frame8 irq done");
    wr(ra(1, DVL), 8'h01);
    tx_frame(1, 8'hc9, 8'h3c, 11, 32, {2'b11, 8'h3c, 1'b0});
    $display("test frame9 tx done");
    wr(ra(0, CTL), 8'h51);
    far0.send_frame({1'b1, 8'h96, 1'b0}, 10, 16);
    rd(ra(0, DAT));
    chk("rx8 data", 32'h96, rv);
    rd(ra(0, CTL));
    chk("rx8 ninth", 32'h1, {31'h0, rv[edu_pkg::CTRL_RB8]});
    wr(ICL, 8'h3f);
    far0.send_frame(11'h000, 1, 4);
    repeat (40) @(posedge clk);
    rd(IST);
    chk("false start", 32'h0, rv);
    wr(ra(1, CTL), 8'hd1);
    far1.send_frame({2'b10, 8'h69, 1'b0}, 11, 32);
    rd(ra(1, DAT));
    chk("rx9 data", 32'h69, rv);
    rd(ra(1, CTL));
    chk("rx9 ninth", 32'h0, {31'h0, rv[edu_pkg::CTRL_RB8]});
    $display("test receive done");
    for (int s = 0; s < 2; s++) begin
      wr(PCN, s == 1 ? 8'h80 : 8'h00);
      tx_frame(0, 8'h80, 8'h5c, 11, s == 1 ? 16 : 32, {2'b10, 8'h5c, 1'b0});
    end
    t1_run <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(PCN, s == 1 ? 8'h80 : 8'h00);
      tx_frame(1, 8'h40, 8'hc3, 10, s == 1 ? 32 : 64, {1'b1, 8'hc3, 1'b0});
    end
    t1_run <= 1'b0;
    $display("test rate sources done");
    wr(ra(0, DVL), 8'h03);
    wr(ra(0, CTL), 8'h00);
    fork
      wr(ra(0, DAT), 8'hb4);
      far0.get_shift(sd, span);
    join
    chk("shift tx data", 32'hb4, {24'h0, sd});
    chk("shift span", 32'd112, 32'(span));
    // last shift bit still running: receive start is ignored while busy
    do begin
      rd(ra(0, STA));
    end while (rv[edu_pkg::STAT_TXB] !== 1'b0);
    fork
      wr(ra(0, CTL), 8'h10);
      far0.feed_shift(8'h4b);
    join
    rd(ra(0, DAT));
    chk("shift rx data", 32'h4b, rv);
    wr(ra(0, CTL), 8'h00);
    $display("test shift done");
    wr(ra(1, CTL), 8'h51);
    wr(ICL, 8'h3f);
    fork
      far1.send_frame(11'h000, 11, 36);
      begin
        repeat (380) @(posedge clk);
        rd(ra(1, STA));
      end
    join
    chk("break flag", 32'h1, {31'h0, rv[edu_pkg::STAT_BRK]});
    rd(IST);
    chk("break event", 32'h1, {31'h0, rv[5]});
    rd(ra(1, STA));
    chk("break gone", 32'h0, {31'h0, rv[edu_pkg::STAT_BRK]});
    $display("test break done");
    final_report();
  end
endmodule
